// [hdl/fpafr_top.sv]
// front panel supervision: fault relay, address decode, pushbutton and register slave
// Function
// [R1] relay closes on no fault, optionally also enabled
// [R2] relay ignores enable, thermal limit, regen otherwise
// [R3] fault opens relay; open relay inhibits output stage
// [R4] display shows drive status after power-up
// [R5] short press flashes the ip address
// [R6] switches zero select dhcp with link-local fallback
// [R7] switches 01-99 give static last octet
// [R8] switch value is also fieldbus node address
// [R9] switches latched only at power-up
// [R10] source select one uses software static address
// [R11] dhcp mode independent of switches, node kept
// [R12] zero switches, 5 s hold restores defaults
// [R13] host reconfigures and stores ip settings afterwards
// [R14] host saves parameters after output assignment
// [R15] output stage needs hardware and software enable
// [R16] pushbutton debounced, press length counted on clock
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module fpafr_top #(
	parameter int TICK_CYCLES = fpafr_pkg::TICK_CYCLES,
	parameter int HOLD_MS = fpafr_pkg::HOLD_MS,
	parameter int SHOW_MS = fpafr_pkg::SHOW_MS,
	parameter int DEBOUNCE_MS = fpafr_pkg::DEBOUNCE_MS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic drive_fault,
	input wire logic hw_enable_pin,
	input wire logic front_pushbutton,
	input wire logic [3:0] tens_digit_switch,
	input wire logic [3:0] units_digit_switch,
	output logic relay_close,
	output logic stage_enable,
	output logic [1:0] disp_sel,
	output logic disp_flash,
	output logic [1:0] ip_source_select,
	output logic [7:0] ip_last_octet,
	output logic [7:0] node_addr,
	output logic ip_restore,
	output logic dhcp_start
);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	function automatic fpafr_pkg::fpafr_ipmode_t ip_decode(input logic [1:0] sel, input logic [7:0] sw,
		input logic force_dhcp);
		if (force_dhcp) begin
			ip_decode = fpafr_pkg::IPM_DHCP;
		end else if (sel == fpafr_pkg::IPSEL_SOFT) begin
			ip_decode = fpafr_pkg::IPM_SOFT; // [R10]
		end else if (sel == fpafr_pkg::IPSEL_DHCP || sw == 8'h00) begin
			ip_decode = fpafr_pkg::IPM_DHCP; // [R6] [R11]
		end else begin
			ip_decode = fpafr_pkg::IPM_STATIC_SW; // [R7]
		end
	endfunction

	logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
	logic tick_r, tick_nxt;

	fpafr_pnl_if pnl ();

	fpafr_button #(
		.DEBOUNCE_MS(DEBOUNCE_MS),
		.HOLD_MS(HOLD_MS)
	) u_button (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick_ms(tick_r),
		.front_pushbutton(front_pushbutton),
		.pnl(pnl.btn)
	);

	fpafr_switch_latch u_switch (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tens_digit_switch(tens_digit_switch),
		.units_digit_switch(units_digit_switch),
		.pnl(pnl.sw)
	);

	// millisecond enable
	always_comb begin
		tick_nxt = (tick_cnt_r == TW'(TICK_CYCLES - 1));
		tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + TW'(1);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	// enable pin synchroniser and relay chain
	logic [2:0] en_sync_r, en_sync_nxt;
	logic hw_en_r, hw_en_nxt;
	logic relay_r, relay_nxt;
	logic stage_r, stage_nxt;
	logic fault_d_r;
	logic [fpafr_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic relay_mode, sw_en;
	logic [1:0] ipsel;

	assign relay_mode = ctrl_r[fpafr_pkg::CTRL_RELAY_MODE_BIT];
	assign sw_en = ctrl_r[fpafr_pkg::CTRL_SW_EN_BIT];
	assign ipsel = ctrl_r[fpafr_pkg::CTRL_IPSEL_LSB +: 2];

	always_comb begin
		en_sync_nxt = {en_sync_r[1:0], hw_enable_pin};
		hw_en_nxt = (en_sync_r[1] == en_sync_r[2]) ? en_sync_r[2] : hw_en_r;
		// only fault and, in mode one, the enable chain reach the contact
		relay_nxt = !drive_fault && (!relay_mode || (hw_en_r && sw_en)); // [R1] [R2] [R3]
		stage_nxt = !drive_fault && relay_nxt && hw_en_r && sw_en; // [R3] [R15]
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			en_sync_r <= 3'h0;
			hw_en_r <= 1'b0;
			relay_r <= 1'b0;
			stage_r <= 1'b0;
			fault_d_r <= 1'b0;
		end else begin
			en_sync_r <= en_sync_nxt;
			hw_en_r <= hw_en_nxt;
			relay_r <= relay_nxt;
			stage_r <= stage_nxt;
			fault_d_r <= drive_fault;
		end
	end

	// address decode from the power-up switch value
	logic [7:0] sw_val;
	logic [7:0] node_r, octet_r;
	logic [1:0] ipm_r;
	logic force_dhcp_r, force_dhcp_nxt;
	fpafr_pkg::fpafr_ipmode_t ipm_nxt;

	assign sw_val = {4'h0, pnl.tens} * 8'h0A + {4'h0, pnl.units};

	always_comb begin
		ipm_nxt = ip_decode(ipsel, sw_val, force_dhcp_r);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			node_r <= 8'h00;
			octet_r <= 8'h00;
			ipm_r <= fpafr_pkg::IPM_DHCP;
		end else begin
			node_r <= sw_val; // [R8]
			octet_r <= (ipm_nxt == fpafr_pkg::IPM_STATIC_SW) ? sw_val : 8'h00; // [R7]
			ipm_r <= ipm_nxt;
		end
	end

	// display sequencer
	fpafr_pkg::fpafr_state_t st_r, st_nxt;
	logic [15:0] show_r, show_nxt;
	logic restore_r, restore_nxt;
	logic dhcp_r, dhcp_nxt;
	logic [1:0] disp_r, disp_nxt;
	logic recover;

	assign recover = pnl.btn_long && pnl.sw_live_zero; // [R12]

	always_comb begin
		st_nxt = st_r;
		show_nxt = show_r;
		restore_nxt = 1'b0;
		dhcp_nxt = 1'b0;
		force_dhcp_nxt = force_dhcp_r;
		case (st_r)
			fpafr_pkg::ST_STATUS: begin
				show_nxt = 16'h0000;
				if (recover) begin
					st_nxt = fpafr_pkg::ST_FLASH_ZERO; // [R12]
					restore_nxt = 1'b1;
					force_dhcp_nxt = 1'b1;
				end else if (pnl.btn_short) begin
					st_nxt = fpafr_pkg::ST_SHOW_IP; // [R5]
				end
			end
			fpafr_pkg::ST_SHOW_IP, fpafr_pkg::ST_FLASH_ZERO: begin
				if (tick_r) begin
					if (show_r == 16'(SHOW_MS - 1)) begin
						st_nxt = fpafr_pkg::ST_STATUS;
						dhcp_nxt = (st_r == fpafr_pkg::ST_FLASH_ZERO); // [R12]
					end else begin
						show_nxt = show_r + 16'h0001;
					end
				end
			end
			default: begin
				st_nxt = fpafr_pkg::ST_STATUS;
			end
		endcase
		case (st_nxt)
			fpafr_pkg::ST_SHOW_IP: disp_nxt = fpafr_pkg::DISP_IP;
			fpafr_pkg::ST_FLASH_ZERO: disp_nxt = fpafr_pkg::DISP_ZERO;
			default: disp_nxt = fpafr_pkg::DISP_STATUS; // [R4]
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= fpafr_pkg::ST_STATUS;
			show_r <= 16'h0000;
			restore_r <= 1'b0;
			dhcp_r <= 1'b0;
			force_dhcp_r <= 1'b0;
			disp_r <= fpafr_pkg::DISP_STATUS;
		end else begin
			st_r <= st_nxt;
			show_r <= show_nxt;
			restore_r <= restore_nxt;
			dhcp_r <= dhcp_nxt;
			force_dhcp_r <= force_dhcp_nxt;
			disp_r <= disp_nxt;
		end
	end

	// register slave, one wait cycle per access
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt, rmux;
	logic [fpafr_pkg::IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt, events;
	logic wr_fire;

	assign wr_fire = avs_write && ack_r && avs_byteenable[0];
	assign events = {pnl.sw_latched && drive_fault && !fault_d_r, recover, pnl.btn_short};

	always_comb begin
		ack_nxt = (avs_read || avs_write) && !ack_r;
		case (avs_address)
			fpafr_pkg::OFS_CTRL: rmux = {28'h0, ctrl_r};
			fpafr_pkg::OFS_STATUS: rmux = {24'h0, ipm_r, pnl.btn_level, pnl.sw_latched, drive_fault, hw_en_r,
				stage_r, relay_r};
			fpafr_pkg::OFS_ADDR: rmux = {7'h0, pnl.sw_latched, pnl.units, pnl.tens, node_r, octet_r};
			fpafr_pkg::OFS_IRQ_STAT: rmux = {29'h0, istat_r};
			fpafr_pkg::OFS_IRQ_MASK: rmux = {29'h0, imask_r};
			default: rmux = 32'h0000_0000;
		endcase
		rdata_nxt = (avs_read && !ack_r) ? rmux : rdata_r;
		ctrl_nxt = ctrl_r;
		imask_nxt = imask_r;
		istat_nxt = istat_r;
		if (wr_fire && avs_address == fpafr_pkg::OFS_CTRL) begin
			ctrl_nxt = avs_writedata[fpafr_pkg::CTRL_W-1:0];
		end
		if (wr_fire && avs_address == fpafr_pkg::OFS_IRQ_MASK) begin
			imask_nxt = avs_writedata[fpafr_pkg::IRQ_W-1:0];
		end
		if (wr_fire && avs_address == fpafr_pkg::OFS_IRQ_STAT) begin
			istat_nxt = istat_r & ~avs_writedata[fpafr_pkg::IRQ_W-1:0];
		end
		istat_nxt = istat_nxt | events;
		if (restore_nxt) begin
			ctrl_nxt[fpafr_pkg::CTRL_IPSEL_LSB +: 2] = fpafr_pkg::IPSEL_SWITCH; // [R12]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			ctrl_r <= fpafr_pkg::CTRL_RESET;
			imask_r <= fpafr_pkg::IRQ_MASK_RESET;
			istat_r <= 3'h0;
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			ctrl_r <= ctrl_nxt;
			imask_r <= imask_nxt;
			istat_r <= istat_nxt;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign avs_readdata = rdata_r;
	assign irq = |(istat_r & imask_r);
	assign relay_close = relay_r;
	assign stage_enable = stage_r;
	assign disp_sel = disp_r;
	assign disp_flash = (st_r != fpafr_pkg::ST_STATUS);
	assign ip_source_select = ipm_r;
	assign ip_last_octet = octet_r;
	assign node_addr = node_r;
	assign ip_restore = restore_r;
	assign dhcp_start = dhcp_r;

	sequence seq_recover_start;
		recover && st_r == fpafr_pkg::ST_STATUS;
	endsequence
	sequence seq_zero_shown;
		restore_r && st_r == fpafr_pkg::ST_FLASH_ZERO && disp_r == fpafr_pkg::DISP_ZERO ##1 !restore_r && disp_flash;
	endsequence

	a_relay_no_fault: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
		!drive_fault && !relay_mode |=> relay_close)
		else $error("relay open without fault in mode zero");
	a_relay_ignores_en: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
		(!drive_fault && !relay_mode)[*3] |-> relay_close && $stable(relay_close))
		else $error("relay followed enable in mode zero");
	a_fault_opens: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
		drive_fault |=> !relay_close && !stage_enable)
		else $error("fault did not open relay and stage");
	a_stage_needs_relay: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
		stage_enable |-> relay_close)
		else $error("stage enabled with relay open");
	a_enable_chain: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
		stage_enable |-> $past(hw_en_r) && $past(sw_en))
		else $error("stage enabled without both enables");
	a_boot_status: assert property (@(posedge core_clk) disable iff (!rst_n) // [R4]
		!$past(rst_n) |-> disp_sel == fpafr_pkg::DISP_STATUS && !disp_flash)
		else $error("display not on status after reset");
	a_short_shows_ip: assert property (@(posedge core_clk) disable iff (!rst_n) // [R5]
		pnl.btn_short && !recover && st_r == fpafr_pkg::ST_STATUS |=> disp_sel == fpafr_pkg::DISP_IP && disp_flash)
		else $error("short press did not show the address");
	a_recover_seq: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12]
		seq_recover_start |=> seq_zero_shown)
		else $error("recovery did not restore and flash zeros");
	a_static_octet: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
		ip_source_select == fpafr_pkg::IPM_STATIC_SW |-> ip_last_octet == node_addr && node_addr != 8'h00)
		else $error("static octet differs from switch value");
	a_zero_dhcp: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
		sw_val == 8'h00 && ipsel != fpafr_pkg::IPSEL_SOFT |=> ip_source_select == fpafr_pkg::IPM_DHCP)
		else $error("zero switches did not select dhcp");
	a_soft_ip: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
		ipsel == fpafr_pkg::IPSEL_SOFT && !force_dhcp_r |=> ip_source_select == fpafr_pkg::IPM_SOFT)
		else $error("software address not selected");
	a_dhcp_indep: assert property (@(posedge core_clk) disable iff (!rst_n) // [R11]
		ipsel == fpafr_pkg::IPSEL_DHCP |=> ip_source_select == fpafr_pkg::IPM_DHCP && node_addr == $past(sw_val))
		else $error("dhcp mode lost dhcp or node address");
	a_node_addr: assert property (@(posedge core_clk) disable iff (!rst_n) // [R8]
		pnl.sw_latched ##1 pnl.sw_latched |-> node_addr == {4'h0, pnl.tens} * 8'h0A + {4'h0, pnl.units})
		else $error("node address differs from switch value");
endmodule

// [hdl/fpafr_pkg.sv]
// constants, field layouts and types of the front panel supervision block
package fpafr_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int HOLD_S = 5;
	localparam int HOLD_MS = HOLD_S * 1000;
	localparam int DEBOUNCE_MS = 20;
	localparam int SHOW_S = 3;
	localparam int SHOW_MS = SHOW_S * 1000;
	localparam int SYNC_STAGES = 3;
	localparam int SETTLE_CYCLES = 4;

	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_STATUS = 6'h04;
	localparam logic [5:0] OFS_ADDR = 6'h08;
	localparam logic [5:0] OFS_IRQ_STAT = 6'h0C;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h10;

	localparam int CTRL_RELAY_MODE_BIT = 0;
	localparam int CTRL_SW_EN_BIT = 1;
	localparam int CTRL_IPSEL_LSB = 2;
	localparam int CTRL_W = 4;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	localparam int IRQ_SHORT_BIT = 0;
	localparam int IRQ_RECOVER_BIT = 1;
	localparam int IRQ_FAULT_BIT = 2;
	localparam int IRQ_W = 3;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	localparam int ADDR_NODE_LSB = 8;
	localparam int ADDR_TENS_LSB = 16;
	localparam int ADDR_UNITS_LSB = 20;
	localparam int ADDR_LATCHED_BIT = 24;

	localparam logic [1:0] IPSEL_SWITCH = 2'h0;
	localparam logic [1:0] IPSEL_SOFT = 2'h1;
	localparam logic [1:0] IPSEL_DHCP = 2'h2;

	typedef enum logic [1:0] {IPM_DHCP = 2'h0, IPM_STATIC_SW = 2'h1, IPM_SOFT = 2'h2} fpafr_ipmode_t;
	typedef enum logic [1:0] {DISP_STATUS = 2'h0, DISP_IP = 2'h1, DISP_ZERO = 2'h2} fpafr_disp_t;
	typedef enum logic [2:0] {ST_STATUS = 3'b001, ST_SHOW_IP = 3'b010, ST_FLASH_ZERO = 3'b100} fpafr_state_t;
endpackage

// [hdl/fpafr_pnl_if.sv]
// carrier between the panel input modules and the core
`timescale 1ns/1ps
interface fpafr_pnl_if;
	logic btn_short;
	logic btn_long;
	logic btn_level;
	logic [3:0] tens;
	logic [3:0] units;
	logic sw_latched;
	logic sw_live_zero;
	modport btn (output btn_short, output btn_long, output btn_level);
	modport sw (output tens, output units, output sw_latched, output sw_live_zero);
	modport core (input btn_short, input btn_long, input btn_level, input tens, input units,
		input sw_latched, input sw_live_zero);
endinterface

// [hdl/fpafr_button.sv]
// pushbutton synchroniser, debouncer and press length classifier
`timescale 1ns/1ps
module fpafr_button #(
	parameter int DEBOUNCE_MS = fpafr_pkg::DEBOUNCE_MS,
	parameter int HOLD_MS = fpafr_pkg::HOLD_MS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tick_ms,
	input wire logic front_pushbutton,
	fpafr_pnl_if.btn pnl
);
	logic [2:0] sync_r, sync_nxt;
	logic stable_r, stable_nxt;
	logic [15:0] deb_r, deb_nxt;
	logic [15:0] hold_r, hold_nxt;
	logic long_done_r, long_done_nxt;
	logic short_r, short_nxt;
	logic long_r, long_nxt;

	always_comb begin
		sync_nxt = {sync_r[1:0], front_pushbutton};
		stable_nxt = stable_r;
		deb_nxt = deb_r;
		hold_nxt = hold_r;
		long_done_nxt = long_done_r;
		short_nxt = 1'b0;
		long_nxt = 1'b0;
		// a change counts only while the last two stages agree
		if (sync_r[1] != sync_r[2] || sync_r[2] == stable_r) begin // [R16]
			deb_nxt = 16'h0000;
		end else if (tick_ms) begin
			if (deb_r == 16'(DEBOUNCE_MS - 1)) begin // [R16]
				stable_nxt = sync_r[2];
				deb_nxt = 16'h0000;
			end else begin
				deb_nxt = deb_r + 16'h0001;
			end
		end
		if (stable_r) begin
			if (tick_ms && !long_done_r) begin
				if (hold_r == 16'(HOLD_MS - 1)) begin // [R16]
					long_nxt = 1'b1;
					long_done_nxt = 1'b1;
				end else begin
					hold_nxt = hold_r + 16'h0001;
				end
			end
			if (!stable_nxt) begin
				short_nxt = !long_done_r; // [R16]
				// a release on the tick that ends the hold counts as short
				long_nxt = 1'b0;
				hold_nxt = 16'h0000;
				long_done_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync_r <= 3'h0;
			stable_r <= 1'b0;
			deb_r <= 16'h0000;
			hold_r <= 16'h0000;
			long_done_r <= 1'b0;
			short_r <= 1'b0;
			long_r <= 1'b0;
		end else begin
			sync_r <= sync_nxt;
			stable_r <= stable_nxt;
			deb_r <= deb_nxt;
			hold_r <= hold_nxt;
			long_done_r <= long_done_nxt;
			short_r <= short_nxt;
			long_r <= long_nxt;
		end
	end

	assign pnl.btn_short = short_r;
	assign pnl.btn_long = long_r;
	assign pnl.btn_level = stable_r;

	a_short_release: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
		short_r |-> !stable_r && $past(stable_r) && !$past(long_done_r))
		else $error("short press without release of a short hold");
	a_long_hold_time: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
		long_r |-> stable_r && $past(hold_r) == 16'(HOLD_MS - 1))
		else $error("long press before the hold time");
endmodule

// [hdl/fpafr_switch_latch.sv]
// rotary switch synchroniser with one capture after power-up
`timescale 1ns/1ps
module fpafr_switch_latch (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [3:0] tens_digit_switch,
	input wire logic [3:0] units_digit_switch,
	fpafr_pnl_if.sw pnl
);
	logic [7:0] s1_r, s2_r, s3_r;
	logic [2:0] settle_r, settle_nxt;
	logic latched_r, latched_nxt;
	logic [7:0] val_r, val_nxt;
	logic zero_r, zero_nxt;

	always_comb begin
		settle_nxt = settle_r;
		latched_nxt = latched_r;
		val_nxt = val_r;
		zero_nxt = (s2_r == s3_r) ? (s3_r == 8'h00) : zero_r;
		if (!latched_r) begin
			if (s2_r != s3_r) begin
				settle_nxt = 3'h0;
			end else if (settle_r == 3'(fpafr_pkg::SETTLE_CYCLES - 1)) begin
				latched_nxt = 1'b1; // [R9]
				val_nxt = s3_r;
			end else begin
				settle_nxt = settle_r + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s1_r <= 8'h00;
			s2_r <= 8'h00;
			s3_r <= 8'h00;
			settle_r <= 3'h0;
			latched_r <= 1'b0;
			val_r <= 8'h00;
			zero_r <= 1'b0;
		end else begin
			s1_r <= {tens_digit_switch, units_digit_switch};
			s2_r <= s1_r;
			s3_r <= s2_r;
			settle_r <= settle_nxt;
			latched_r <= latched_nxt;
			val_r <= val_nxt;
			zero_r <= zero_nxt;
		end
	end

	assign pnl.tens = val_r[7:4];
	assign pnl.units = val_r[3:0];
	assign pnl.sw_latched = latched_r;
	assign pnl.sw_live_zero = zero_r;

	a_switch_frozen: assert property (@(posedge core_clk) disable iff (!rst_n) // [R9]
		$past(latched_r) |-> latched_r && $stable(val_r))
		else $error("latched switch value changed while powered");
endmodule

// [sim/fpafr_operator.sv]
// operator model at the front panel: presses the pushbutton with contact bounce
`timescale 1ns/1ps
module fpafr_operator (
	input wire logic core_clk,
	output logic front_pushbutton
);
	initial front_pushbutton = 1'b0;

	// bounce at both edges stays shorter than the debounce window
	task automatic press(input int hold_cycles);
		int i;
		for (i = 0; i < 5; i++) begin
			@(posedge core_clk);
			front_pushbutton <= ~i[0];
		end
		repeat (hold_cycles) @(posedge core_clk);
		for (i = 0; i < 5; i++) begin
			@(posedge core_clk);
			front_pushbutton <= i[0];
		end
		@(posedge core_clk);
		front_pushbutton <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask
endmodule

// [sim/fpafr_top_bench.sv]
// self-checking bench of the front panel supervision block
`timescale 1ns/1ps
module fpafr_top_bench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, irq, relay_close, stage_enable, disp_flash, ip_restore, dhcp_start;
	logic drive_fault = 1'b0;
	logic hw_enable_pin = 1'b0;
	logic front_pushbutton;
	logic [3:0] tens_digit_switch = 4'h0;
	logic [3:0] units_digit_switch = 4'h0;
	logic [1:0] disp_sel, ip_source_select;
	logic [7:0] ip_last_octet, node_addr;
	logic [63:0] exp_q[$];
	logic [63:0] note;
	logic [31:0] seed = 32'h3C;
	logic [1:0] mode_tab [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
	int fails = 0;
	int compares = 0;

	always #2.5 core_clk = ~core_clk;

	fpafr_top #(.TICK_CYCLES(4), .HOLD_MS(6), .SHOW_MS(5), .DEBOUNCE_MS(2)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.drive_fault(drive_fault), .hw_enable_pin(hw_enable_pin), .front_pushbutton(front_pushbutton),
		.tens_digit_switch(tens_digit_switch), .units_digit_switch(units_digit_switch),
		.relay_close(relay_close), .stage_enable(stage_enable), .disp_sel(disp_sel),
		.disp_flash(disp_flash), .ip_source_select(ip_source_select), .ip_last_octet(ip_last_octet),
		.node_addr(node_addr), .ip_restore(ip_restore), .dhcp_start(dhcp_start));

	fpafr_operator op (.core_clk(core_clk), .front_pushbutton(front_pushbutton));

	task automatic end_of_test();
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// one Avalon access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			fails++;
			end_of_test();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] mask);
		exp_q.push_back({mask, exp});
		bus(1'b0, a, 32'h0, 4'hF);
	endtask

	// read data are compared against the oldest note at the edge they are taken
	always @(posedge core_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("CHECK FAILED readdata expected none seen %h", avs_readdata);
			end else begin
				note = exp_q.pop_front();
				chk("readdata", note[31:0], avs_readdata & note[63:32]);
			end
		end
	end

	task automatic wait_for(input int sel);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge core_clk);
			if ((sel == 0 && ip_restore === 1'b1) || (sel == 1 && dhcp_start === 1'b1)
				|| (sel == 2 && disp_sel === 2'h1) || (sel == 3 && disp_sel === 2'h0)) break;
		end
		if (n >= 400) begin
			fails++;
			end_of_test();
		end
	endtask

	task automatic power_up(input logic [3:0] t, input logic [3:0] u);
		rst_n <= 1'b0;
		tens_digit_switch <= t;
		units_digit_switch <= u;
		repeat (8) @(posedge core_clk);
		chk("relay in reset", 32'h0, 32'(relay_close));
		chk("display after power-up", 32'h0, 32'(disp_sel));
		rst_n <= 1'b1;
		repeat (12) @(posedge core_clk);
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		fails++;
		end_of_test();
	end

	initial begin
		logic [31:0] r;
		logic er;
		logic es;
		int i;
		power_up(4'h4, 4'h5);
		chk("node address", 32'h2D, 32'(node_addr));
		chk("static octet", 32'h2D, 32'(ip_last_octet));
		chk("ip_source_select", 32'h1, 32'(ip_source_select));
		rd(6'h08, 32'h0154_2D2D, 32'h01FF_FFFF);
		r = xs();
		tens_digit_switch <= r[3:0];
		units_digit_switch <= r[7:4];
		repeat (20) @(posedge core_clk);
		chk("node held", 32'h2D, 32'(node_addr));
		rd(6'h14, 32'h0, 32'hFFFF_FFFF);
		wr(6'h14, 32'hFFFF_FFFF);
		bus(1'b1, 6'h00, 32'h3, 4'h0);
		rd(6'h00, 32'h0, 32'hF);
		rd(6'h10, 32'h0, 32'h7);
		for (i = 0; i < 24; i++) begin
			r = xs();
			bus(1'b1, 6'h00, {30'h0, r[1:0]}, {r[7:5], 1'b1});
			drive_fault <= r[2];
			hw_enable_pin <= r[3];
			repeat (8) @(posedge core_clk);
			er = ~r[2] & (~r[0] | (r[3] & r[1]));
			es = er & r[3] & r[1];
			chk("relay", 32'(er), 32'(relay_close));
			chk("stage", 32'(es), 32'(stage_enable));
		end
		rd(6'h04, {28'h0, r[2], r[3], es, er}, 32'hF);
		drive_fault <= 1'b0;
		for (i = 0; i < 4; i++) begin
			wr(6'h00, 32'(i << 2));
			repeat (3) @(posedge core_clk);
			chk("ip_source_select", 32'(mode_tab[i]), 32'(ip_source_select));
			chk("octet", mode_tab[i] == 2'h1 ? 32'h2D : 32'h0, 32'(ip_last_octet));
			chk("node kept", 32'h2D, 32'(node_addr));
		end
		wr(6'h0C, 32'h7);
		fork
			op.press(14);
			wait_for(2);
		join
		chk("show ip flash", 32'h1, 32'(disp_flash));
		wait_for(3);
		rd(6'h0C, 32'h1, 32'h1);
		chk("irq masked", 32'h0, 32'(irq));
		wr(6'h10, 32'h1);
		@(posedge core_clk);
		chk("irq raised", 32'h1, 32'(irq));
		wr(6'h0C, 32'h1);
		@(posedge core_clk);
		chk("irq cleared", 32'h0, 32'(irq));
		rd(6'h0C, 32'h0, 32'h1);
		power_up(4'h0, 4'h0);
		chk("dhcp mode", 32'h0, 32'(ip_source_select));
		chk("dhcp octet", 32'h0, 32'(ip_last_octet));
		chk("node zero", 32'h0, 32'(node_addr));
		fork
			op.press(60);
			begin
				wait_for(0);
				chk("zero display", 32'h2, 32'(disp_sel));
				chk("zero flash", 32'h1, 32'(disp_flash));
				wait_for(1);
				wait_for(3);
			end
		join
		chk("mode after restore", 32'h0, 32'(ip_source_select));
		rd(6'h0C, 32'h2, 32'h2);
		wr(6'h00, 32'h4);
		end_of_test();
	end
endmodule
